/* File: verilog/ptsg_pkg.sv */
/*
 * Constants and carrier types for the PWM trigger and sync glue.
 * Assumes one high-speed peripheral clock drives the glue and all sources.
 */
package ptsg_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PWM = 12;
    localparam int NUM_ADC_PWM = 9;
    localparam int NUM_PIN_TRIP = 12;
    localparam int NUM_TZ_PIN = 3;
    localparam int TRIP_W = 15;
    localparam int TZ_W = 6;
    localparam int SYNC_STRETCH = 8;
    localparam int SOC_STRETCH = 32;
    localparam int CNT_W = 6;

    // ------------------------------------------------------------
    // Field positions in the trip vectors
    // ------------------------------------------------------------
    localparam int TRIP_RAM_ERR_BIT = 12;
    localparam int TRIP_EXP_ERR_BIT = 13;
    localparam int TZ_ENC_ERR_BIT = 3;
    localparam int TZ_CLK_FAIL_BIT = 4;
    localparam int TZ_HALT_BIT = 5;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PWM-1:0] conversion_trigger_a;
        logic [NUM_PWM-1:0] conversion_trigger_b;
        logic [NUM_PWM-1:0] pwm_event_irq;
        logic [NUM_PWM-1:0] pwm_trip_irq;
        logic [NUM_PWM-1:0] sync_out;
    } ptsg_pwm_out_t;

    typedef struct packed {
        logic [NUM_ADC_PWM-1:0] trig_a;
        logic [NUM_ADC_PWM-1:0] trig_b;
    } ptsg_adc_trig_t;

    typedef struct packed {
        logic [NUM_PIN_TRIP-1:0] pin_trip_line;
        logic ram_double_bit_error;
        logic interrupt_expander_error;
        logic encoder_error;
        logic clock_fail_flag;
        logic debug_halt;
    } ptsg_fault_in_t;
endpackage : ptsg_pkg

/* File: verilog/ptsg_glue.sv */
/*
 * PWM trigger and sync glue: stretches sync and merged conversion triggers,
 * routes ADC triggers, builds trip vectors and fans out interrupts.
 * Assumes all inputs synchronous to clk (the high-speed peripheral clock).
 */
// Operation
// - Stretch module one sync output to 8 clocks toward pin multiplexer.
// - OR twelve trigger A outputs, stretch 32 clocks, send as merged A.
// - OR twelve trigger B outputs, stretch 32 clocks, send as merged B.
// - Route trigger A and B of modules one to nine to analog side.
// - Build fifteen-bit trip vector from pin lines, RAM and expander errors.
// - Build six trip-zone inputs from three pins, encoder, clock fail, halt.
// - Pass twelve event and twelve trip interrupts to interrupt expander.
// - Leave sync outputs of modules three, six, nine, twelve unused.
// - Feed sync inputs from external sync pin and timebase clock gate.
`timescale 1ns/1ns
module ptsg_glue #(
    parameter int SYNC_LEN_CYC = ptsg_pkg::SYNC_STRETCH,
    parameter int SOC_LEN_CYC = ptsg_pkg::SOC_STRETCH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ptsg_pkg::ptsg_pwm_out_t pwm_out,
    input wire ptsg_pkg::ptsg_fault_in_t faults,
    input wire logic external_sync_in,
    input wire logic timebase_clock_gate,
    output logic sync_to_pin,
    output logic merged_trigger_a,
    output logic merged_trigger_b,
    output ptsg_pkg::ptsg_adc_trig_t adc_trig,
    output logic [ptsg_pkg::TRIP_W-1:0] trip_inputs,
    output logic [ptsg_pkg::TZ_W-1:0] trip_zone_inputs,
    output logic [ptsg_pkg::NUM_PWM-1:0] pwm_event_irq,
    output logic [ptsg_pkg::NUM_PWM-1:0] pwm_trip_irq,
    output logic pwm_sync_in,
    output logic pwm_clock_gate
);

    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    // Counters are CNT_W bits wide: a stretch above 63 cycles needs more
    localparam int MOD_ONE = 0;
    localparam int STR_SYNC = 0;
    localparam int STR_CONVERSION_TRIGGER_A = 1;
    localparam int STR_CONVERSION_TRIGGER_B = 2;
    localparam int NUM_STR = 3;
    localparam logic [ptsg_pkg::CNT_W-1:0] SYNC_LEN = ptsg_pkg::CNT_W'(SYNC_LEN_CYC);
    localparam logic [ptsg_pkg::CNT_W-1:0] SOC_LEN = ptsg_pkg::CNT_W'(SOC_LEN_CYC);
    localparam logic [ptsg_pkg::CNT_W-1:0] CNT_ZERO = ptsg_pkg::CNT_W'(0);
    localparam logic [ptsg_pkg::CNT_W-1:0] CNT_ONE = ptsg_pkg::CNT_W'(1);
    localparam logic [ptsg_pkg::TRIP_W-1:0] TRIP_IDLE = '0;
    localparam logic [ptsg_pkg::TZ_W-1:0] TZ_IDLE = '0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Every output is one register behind the inputs sampled at an edge.
    // Stretch length counts from the latest sample, so a held input keeps
    // the line high for its own length plus the stretch, less one cycle.

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic [NUM_STR-1:0] str_pulse;
    logic [ptsg_pkg::CNT_W-1:0] str_cnt [NUM_STR];
    logic [ptsg_pkg::CNT_W-1:0] next_str_cnt [NUM_STR];
    logic next_str_on [NUM_STR];
    logic next_sync_to_pin;
    logic next_merged_trigger_a;
    logic next_merged_trigger_b;
    ptsg_pkg::ptsg_adc_trig_t next_adc;
    logic [ptsg_pkg::TRIP_W-1:0] next_trip;
    logic [ptsg_pkg::TZ_W-1:0] next_tz;
    logic [ptsg_pkg::NUM_PWM-1:0] next_event_irq;
    logic [ptsg_pkg::NUM_PWM-1:0] next_trip_irq;
    logic next_sync_in;
    logic next_clock_gate;

    // ------------------------------------------------------------
    // Stretch sources
    // ------------------------------------------------------------
    always_comb begin
        // Module one only; sync of 3, 6, 9 and 12 is never read
        str_pulse[STR_SYNC] = pwm_out.sync_out[MOD_ONE];
        str_pulse[STR_CONVERSION_TRIGGER_A] = |pwm_out.conversion_trigger_a;
        str_pulse[STR_CONVERSION_TRIGGER_B] = |pwm_out.conversion_trigger_b;
    end

    // ------------------------------------------------------------
    // Stretch counters, one per stretched line
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_STR; g++) begin : g_str
        // Sync line is short, both trigger lines long
        localparam logic [ptsg_pkg::CNT_W-1:0] LEN = (g == STR_SYNC) ? SYNC_LEN : SOC_LEN;

        always_comb begin
            // Reload on every pulse so the window runs from the latest one
            if (str_pulse[g]) begin
                next_str_cnt[g] = LEN;
            end else if (str_cnt[g] != CNT_ZERO) begin
                next_str_cnt[g] = str_cnt[g] - CNT_ONE;
            end else begin
                next_str_cnt[g] = CNT_ZERO;
            end
            next_str_on[g] = next_str_cnt[g] != CNT_ZERO;
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                str_cnt[g] <= CNT_ZERO;
            end else begin
                str_cnt[g] <= next_str_cnt[g];
            end
        end
    end

    // ------------------------------------------------------------
    // Stretched outputs
    // ------------------------------------------------------------
    always_comb begin
        next_sync_to_pin = next_str_on[STR_SYNC];
        next_merged_trigger_a = next_str_on[STR_CONVERSION_TRIGGER_A];
        next_merged_trigger_b = next_str_on[STR_CONVERSION_TRIGGER_B];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_to_pin <= 1'b0;
            merged_trigger_a <= 1'b0;
            merged_trigger_b <= 1'b0;
        end else begin
            // Flopped so the pin side sees no glitches from the OR tree
            sync_to_pin <= next_sync_to_pin;
            merged_trigger_a <= next_merged_trigger_a;
            merged_trigger_b <= next_merged_trigger_b;
        end
    end

    // ------------------------------------------------------------
    // Conversion triggers toward the analog side
    // ------------------------------------------------------------
    always_comb begin
        // Modules ten to twelve do not reach the analog side
        next_adc.trig_a = pwm_out.conversion_trigger_a[ptsg_pkg::NUM_ADC_PWM-1:0];
        next_adc.trig_b = pwm_out.conversion_trigger_b[ptsg_pkg::NUM_ADC_PWM-1:0];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            adc_trig <= '0;
        end else begin
            adc_trig <= next_adc;
        end
    end

    // ------------------------------------------------------------
    // Trip and trip-zone vectors
    // ------------------------------------------------------------
    always_comb begin
        // Top trip bit has no source and stays low
        next_trip = TRIP_IDLE;
        next_trip[ptsg_pkg::NUM_PIN_TRIP-1:0] = faults.pin_trip_line;
        next_trip[ptsg_pkg::TRIP_RAM_ERR_BIT] = faults.ram_double_bit_error;
        next_trip[ptsg_pkg::TRIP_EXP_ERR_BIT] = faults.interrupt_expander_error;
        next_tz = TZ_IDLE;
        next_tz[ptsg_pkg::NUM_TZ_PIN-1:0] = faults.pin_trip_line[ptsg_pkg::NUM_TZ_PIN-1:0];
        next_tz[ptsg_pkg::TZ_ENC_ERR_BIT] = faults.encoder_error;
        next_tz[ptsg_pkg::TZ_CLK_FAIL_BIT] = faults.clock_fail_flag;
        next_tz[ptsg_pkg::TZ_HALT_BIT] = faults.debug_halt;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trip_inputs <= TRIP_IDLE;
            trip_zone_inputs <= TZ_IDLE;
        end else begin
            trip_inputs <= next_trip;
            trip_zone_inputs <= next_tz;
        end
    end

    // ------------------------------------------------------------
    // Interrupt fan-out
    // ------------------------------------------------------------
    always_comb begin
        // One line per module and kind, no merging
        next_event_irq = pwm_out.pwm_event_irq;
        next_trip_irq = pwm_out.pwm_trip_irq;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_event_irq <= '0;
            pwm_trip_irq <= '0;
        end else begin
            pwm_event_irq <= next_event_irq;
            pwm_trip_irq <= next_trip_irq;
        end
    end

    // ------------------------------------------------------------
    // Synchronization feed
    // ------------------------------------------------------------
    always_comb begin
        // Gate bit lives in the clock control register outside the glue
        next_sync_in = external_sync_in;
        next_clock_gate = timebase_clock_gate;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_sync_in <= 1'b0;
            pwm_clock_gate <= 1'b0;
        end else begin
            pwm_sync_in <= next_sync_in;
            pwm_clock_gate <= next_clock_gate;
        end
    end
endmodule : ptsg_glue

/* File: tb/ptsg_glue_asserts.sv */
/* Port checker for ptsg_glue; assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module ptsg_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic external_sync_in,
    input wire logic timebase_clock_gate,
    input wire logic sync_to_pin,
    input wire logic merged_trigger_a,
    input wire logic merged_trigger_b,
    input wire logic pwm_sync_in,
    input wire logic pwm_clock_gate,
    input wire ptsg_pkg::ptsg_pwm_out_t pwm_out,
    input wire ptsg_pkg::ptsg_fault_in_t faults,
    input wire ptsg_pkg::ptsg_adc_trig_t adc_trig,
    input wire logic [14:0] trip_inputs,
    input wire logic [5:0] trip_zone_inputs,
    input wire logic [11:0] pwm_event_irq,
    input wire logic [11:0] pwm_trip_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Age since last pulse saturates, so a long idle never wraps into a stretch
    logic [5:0] age_s, age_a, age_b;
    ptsg_pkg::ptsg_pwm_out_t po;
    ptsg_pkg::ptsg_fault_in_t pf;
    logic pr;
    logic [1:0] pe;
    function automatic logic [5:0] aged(input logic [5:0] a, input logic hit);
        return hit ? 6'h00 : a + {5'h00, a != 6'h3F};
    endfunction : aged
    always_ff @(posedge clk) begin
        age_s <= rst_n ? aged(age_s, pwm_out.sync_out[0]) : 6'h3F;
        age_a <= rst_n ? aged(age_a, |pwm_out.conversion_trigger_a) : 6'h3F;
        age_b <= rst_n ? aged(age_b, |pwm_out.conversion_trigger_b) : 6'h3F;
        po <= pwm_out;
        pf <= faults;
        pr <= rst_n;
        pe <= {external_sync_in, timebase_clock_gate};
    end
    sync_len_a: assert property (sync_to_pin == (age_s < 6'h08)) else $error("sync");
    merge_a_len_a: assert property (merged_trigger_a == (age_a < 6'h20)) else $error("a");
    merge_b_len_a: assert property (merged_trigger_b == (age_b < 6'h20)) else $error("b");
    adc_route_a: assert property (pr |-> adc_trig == {po[56:48], po[44:36]})
        else $error("adc");
    trip_vec_a: assert property (pr |-> trip_inputs == {1'b0, pf[3], pf[4], pf[16:5]})
        else $error("trip");
    tz_vec_a: assert property (pr |-> trip_zone_inputs == {pf[0], pf[1], pf[2], pf[7:5]})
        else $error("tz");
    irq_fan_a: assert property (pr |-> {pwm_event_irq, pwm_trip_irq} == po[35:12])
        else $error("irq");
    sync_feed_a: assert property (pr |-> {pwm_sync_in, pwm_clock_gate} == pe) else $error("feed");
    cover property (merged_trigger_a && |pwm_out.conversion_trigger_a);
    cover property ($fell(sync_to_pin));
    cover property ($fell(merged_trigger_b));
endmodule : ptsg_chk

/* File: tb/ptsg_pinmux_model.sv */
/* Pin multiplexer side: records widths of the stretched lines; assumes the glue clock. */
`timescale 1ns/1ns
module ptsg_pinmux_model (
    input wire logic clk,
    input wire logic [2:0] lvl,
    output logic [2:0][7:0] width
);
    logic [2:0][7:0] run = '0;
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            run[i] <= lvl[i] ? run[i] + 8'h01 : 8'h00;
            if (!lvl[i] && run[i] != 8'h00) width[i] <= run[i];
        end
    end
endmodule : ptsg_pinmux_model

/* File: tb/tb_ptsg_glue.sv */
/* Directed bench for ptsg_glue; assumes the checker and pin multiplexer model. */
`timescale 1ns/1ns
module tb_ptsg_glue;
    logic clk = 1'b0, rst_n = 1'b0, external_sync_in = 1'b0, timebase_clock_gate = 1'b0;
    logic sync_to_pin, merged_trigger_a, merged_trigger_b, pwm_sync_in, pwm_clock_gate;
    ptsg_pkg::ptsg_pwm_out_t pwm_out = '0;
    ptsg_pkg::ptsg_fault_in_t faults = '0;
    ptsg_pkg::ptsg_adc_trig_t adc_trig;
    logic [14:0] trip_inputs;
    logic [5:0] trip_zone_inputs;
    logic [11:0] pwm_event_irq, pwm_trip_irq;
    logic [2:0][7:0] width;
    int bad_count = 0, check_count = 0;
    always #50 clk = ~clk;
    ptsg_glue dut (
        .clk(clk),
        .rst_n(rst_n),
        .pwm_out(pwm_out),
        .faults(faults),
        .external_sync_in(external_sync_in),
        .timebase_clock_gate(timebase_clock_gate),
        .sync_to_pin(sync_to_pin),
        .merged_trigger_a(merged_trigger_a),
        .merged_trigger_b(merged_trigger_b),
        .adc_trig(adc_trig),
        .trip_inputs(trip_inputs),
        .trip_zone_inputs(trip_zone_inputs),
        .pwm_event_irq(pwm_event_irq),
        .pwm_trip_irq(pwm_trip_irq),
        .pwm_sync_in(pwm_sync_in),
        .pwm_clock_gate(pwm_clock_gate)
    );
    ptsg_pinmux_model pinmux (.clk(clk), .lvl({merged_trigger_b, merged_trigger_a, sync_to_pin}),
        .width(width));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : step
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic test_sync;
        // Other modules' sync right after must not lengthen the pulse
        pwm_out.sync_out = 12'h001;
        step(1);
        pwm_out.sync_out = 12'hFFE;
        step(1);
        pwm_out.sync_out = 12'h000;
        step(12);
        chk(width[0], 8'h08);
        $display("sync test done");
    endtask : test_sync
    task automatic test_merge;
        // Second A pulse inside the first window restarts the count
        pwm_out.conversion_trigger_a = 12'h800;
        pwm_out.conversion_trigger_b = 12'h001;
        step(1);
        pwm_out = '0;
        step(9);
        pwm_out.conversion_trigger_a = 12'h010;
        step(1);
        pwm_out = '0;
        step(40);
        chk(width[1], 8'h2A);
        chk(width[2], 8'h20);
        $display("merge test done");
    endtask : test_merge
    task automatic test_route;
        pwm_out = {12'hA5A, 12'h5A5, 12'hC3C, 12'h3C3, 12'h000};
        faults = {12'h9A6, 5'h1B};
        {external_sync_in, timebase_clock_gate} = 2'h3;
        step(1);
        chk(adc_trig, {9'h05A, 9'h1A5});
        chk(trip_inputs, 15'h39A6);
        chk(trip_zone_inputs, 6'h36);
        chk({pwm_event_irq, pwm_trip_irq}, 24'hC3C3C3);
        chk({pwm_sync_in, pwm_clock_gate}, 2'h3);
        pwm_out = '0;
        faults = '0;
        {external_sync_in, timebase_clock_gate} = 2'h0;
        step(40);
        chk(width[1], 8'h20);
        $display("route test done");
    endtask : test_route
    initial begin
        step(6);
        rst_n = 1'b1;
        test_sync;
        test_merge;
        test_route;
        final_report;
    end
endmodule : tb_ptsg_glue
bind ptsg_glue ptsg_chk chk (
    .clk(clk),
    .rst_n(rst_n),
    .external_sync_in(external_sync_in),
    .timebase_clock_gate(timebase_clock_gate),
    .sync_to_pin(sync_to_pin),
    .merged_trigger_a(merged_trigger_a),
    .merged_trigger_b(merged_trigger_b),
    .pwm_sync_in(pwm_sync_in),
    .pwm_clock_gate(pwm_clock_gate),
    .pwm_out(pwm_out),
    .faults(faults),
    .adc_trig(adc_trig),
    .trip_inputs(trip_inputs),
    .trip_zone_inputs(trip_zone_inputs),
    .pwm_event_irq(pwm_event_irq),
    .pwm_trip_irq(pwm_trip_irq)
);
